// ### verilog/csw_watchdog.sv
// Supervision watchdog: control bytes, timeout, latched safe state, backup mirror
`timescale 1ns/10ps
`include "csw_params.svh"
// ==========================================================
// How it works
// R1 - Compare expected model against own identity
// R2 - Transfer mode byte has no effect
// R3 - Select 0 off, 1..10 give 16ms..8s
// R4 - Gap over timeout enters safe state
// R5 - Bad-integrity cycle does not restart timer
// R6 - Safe state turns digital outputs off
// R7 - Safe state tristates PWM outputs
// R8 - Safe entry with backup on saves data
// R9 - Safe lamp flashes cause unless disabled
// R10 - Safe state held until power cycle
// R11 - Force bit resets zero, sets safe
// R12 - Mirror bit selects saved or echoed bytes
// R13 - Mirroring never alters saved backup contents
// R14 - Backup enable resets zero, write enables
// R15 - Host enables backup only when needed
// R16 - Lamp on by default, bit disables
// R17 - Pull-up only for input with output one
// R18 - Host keeps watchdog off during development
// R19 - Valid cycle or select change restarts interval
// R20 - Select codes 11..15 mean disabled
module csw_watchdog #(
	parameter int unsigned BASE_CYC = `CSW_BASE_CYC,
	parameter int unsigned FLASH_CYC = `CSW_FLASH_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Exchange cycle events from the frame receiver
	input wire logic exch_done,
	input wire logic exch_crc_ok,
	// Application outputs before safe gating
	input wire logic [7:0] dout_req,
	input wire logic [3:0] gpio_dir_out,
	// Outputs to the board
	output logic [7:0] dout,
	output logic pwm_oe,
	output logic [3:0] gpio_pullup,
	output logic status_lamp,
	output logic model_mismatch,
	output logic save_strobe,
	output csw_pkg::csw_state_e state
);
	import csw_pkg::*;

	logic [7:0] expected_model_ff;
	logic [7:0] transfer_mode_byte_ff;
	logic [7:0] supervisor_control_zero_ff;
	logic [7:0] supervisor_control_one_ff;
	logic [7:0] general_pin_output_byte_ff;
	logic [7:0] bk_out_ff [0:63];
	logic [7:0] bk_saved_ff [0:63];
	logic [7:0] bk_echo_ff [0:63];
	logic [31:0] wd_cnt_ff;
	logic [3:0] sel_prev_ff;
	csw_state_e state_ff;
	csw_cause_e cause_ff;
	logic [31:0] flash_cnt_ff;
	logic [2:0] flash_ph_ff;
	logic [6:0] save_idx_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic [7:0] dout_ff;
	logic pwm_oe_ff;
	logic [3:0] pullup_ff;
	logic lamp_ff;
	logic mismatch_ff;
	logic save_ff;

	logic wr_en, rd_en, valid_cycle, wd_on, timeout, force_safe, enter_safe;
	logic [3:0] wd_sel;
	logic [31:0] wd_limit;
	logic [5:0] bidx;
	logic bk_out_hit, bk_in_hit;

	// ==========================================================
	// Bus decode
	// Writes land at the edge that samples pready high, never one edge early
	assign wr_en = psel && penable && pwrite && pready_ff;
	assign rd_en = psel && penable && !pwrite && !pready_ff;
	assign bidx = paddr[7:2];
	assign bk_out_hit = (paddr[11:8] == `CSW_OFF_BKOUT >> 8);
	assign bk_in_hit = (paddr[11:8] == `CSW_OFF_BKIN >> 8);
	assign valid_cycle = exch_done && exch_crc_ok; // see R5

	// One wait state: pready rises in the second access cycle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= psel && penable && !pready_ff;
			pslverr_ff <= 1'b0;
			if (psel && penable && !pready_ff) begin
				prdata_ff <= 32'h00000000;
				if (bk_in_hit && !pwrite) begin
					if (supervisor_control_one_ff[`CSW_B_MIRROR]) begin // see R12
						prdata_ff <= {24'h000000, bk_echo_ff[bidx]};
					end else begin
						prdata_ff <= {24'h000000, bk_saved_ff[bidx]};
					end
				end else if (bk_out_hit) begin
					prdata_ff <= {24'h000000, bk_out_ff[bidx]};
				end else begin
					case (paddr)
						`CSW_OFF_MODEL: prdata_ff <= {24'h000000, expected_model_ff};
						`CSW_OFF_XMODE: prdata_ff <= {24'h000000, transfer_mode_byte_ff};
						`CSW_OFF_CTRL0: prdata_ff <= {24'h000000, supervisor_control_zero_ff};
						`CSW_OFF_CTRL1: prdata_ff <= {24'h000000, supervisor_control_one_ff};
						`CSW_OFF_STAT: prdata_ff <= {28'h0000000, mismatch_ff, cause_ff, state_ff == CSW_SAFE};
						`CSW_OFF_GPIO: prdata_ff <= {24'h000000, general_pin_output_byte_ff};
						`CSW_OFF_EXCH: prdata_ff <= 32'h00000000;
						default: pslverr_ff <= !(bk_out_hit || bk_in_hit);
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Control bytes
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			expected_model_ff <= `CSW_RST_MODEL;
			transfer_mode_byte_ff <= `CSW_RST_CTRL;
			supervisor_control_zero_ff <= `CSW_RST_CTRL;
			supervisor_control_one_ff <= `CSW_RST_CTRL; // see R11, R14, R16
			general_pin_output_byte_ff <= `CSW_RST_CTRL;
		end else if (wr_en) begin
			case (paddr)
				`CSW_OFF_MODEL: expected_model_ff <= pwdata[7:0];
				// Stored for readback only; nothing reads it for behaviour
				`CSW_OFF_XMODE: transfer_mode_byte_ff <= pwdata[7:0]; // see R2
				`CSW_OFF_CTRL0: supervisor_control_zero_ff <= {4'h0, pwdata[3:0]};
				`CSW_OFF_CTRL1: supervisor_control_one_ff <= {3'h0, pwdata[4:0]};
				`CSW_OFF_GPIO: general_pin_output_byte_ff <= {4'h0, pwdata[3:0]};
				default: ;
			endcase
		end
	end

	// Outgoing backup bytes; echo copy is taken on the same clock edge as each valid cycle
	always_ff @(posedge mclk) begin
		if (wr_en && bk_out_hit) begin
			bk_out_ff[bidx] <= pwdata[7:0];
		end
		if (valid_cycle) begin
			for (int i = 0; i < 64; i++) begin
				bk_echo_ff[i] <= bk_out_ff[i];
			end
		end
	end

	// Saved backup is written only by the safe-entry save, never by mirroring
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			save_idx_ff <= 7'h00;
			// Limitation: rstn stands for power, so a save survives only until the next rstn
			for (int i = 0; i < 64; i++) begin
				bk_saved_ff[i] <= 8'h00;
			end
		end else if (state_ff == CSW_SAVE) begin
			bk_saved_ff[save_idx_ff[5:0]] <= bk_out_ff[save_idx_ff[5:0]]; // see R8, R13
			save_idx_ff <= save_idx_ff + 7'h01;
		end
	end

	// ==========================================================
	// Watchdog
	assign wd_sel = supervisor_control_zero_ff[3:0];
	assign wd_on = (wd_sel != 4'h0) && (wd_sel <= `CSW_SEL_MAX); // see R3, R20
	assign wd_limit = BASE_CYC << (wd_sel - 4'h1); // see R3
	assign timeout = wd_on && (wd_cnt_ff >= wd_limit - 32'h1); // see R4
	assign force_safe = supervisor_control_one_ff[`CSW_B_SAFE]; // see R11
	assign enter_safe = (state_ff == CSW_RUN) && (timeout || force_safe);

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			wd_cnt_ff <= 32'h00000000;
			sel_prev_ff <= 4'h0;
		end else begin
			sel_prev_ff <= wd_sel;
			if (valid_cycle || wd_sel != sel_prev_ff || !wd_on) begin
				wd_cnt_ff <= 32'h00000000; // see R19
			end else if (!timeout) begin
				wd_cnt_ff <= wd_cnt_ff + 32'h1;
			end
		end
	end

	// Only rstn leaves SAFE; rstn stands in for the power cycle
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			state_ff <= CSW_RUN;
			cause_ff <= CSW_CAUSE_NONE;
		end else begin
			case (state_ff)
				CSW_RUN: begin
					if (enter_safe) begin
						cause_ff <= timeout ? CSW_CAUSE_WDOG : CSW_CAUSE_FORCE;
						state_ff <= supervisor_control_one_ff[`CSW_B_RETAIN] ? CSW_SAVE : CSW_SAFE;
					end
				end
				CSW_SAVE: begin
					if (save_idx_ff == 7'd63) begin
						state_ff <= CSW_SAFE;
					end
				end
				CSW_SAFE: state_ff <= CSW_SAFE; // see R10
				default: state_ff <= CSW_SAFE;
			endcase
		end
	end

	// ==========================================================
	// Lamp flashing: cause count of pulses per eight-phase frame
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			flash_cnt_ff <= 32'h00000000;
			flash_ph_ff <= 3'h0;
		end else if (state_ff != CSW_RUN) begin
			if (flash_cnt_ff >= FLASH_CYC - 1) begin
				flash_cnt_ff <= 32'h00000000;
				flash_ph_ff <= flash_ph_ff + 3'h1;
			end else begin
				flash_cnt_ff <= flash_cnt_ff + 32'h1;
			end
		end
	end

	// ==========================================================
	// Registered outputs
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			dout_ff <= 8'h00;
			pwm_oe_ff <= 1'b0;
			pullup_ff <= 4'h0;
			lamp_ff <= 1'b0;
			mismatch_ff <= 1'b0;
			save_ff <= 1'b0;
		end else begin
			dout_ff <= (state_ff == CSW_RUN && !enter_safe) ? dout_req : 8'h00; // see R6
			pwm_oe_ff <= (state_ff == CSW_RUN && !enter_safe); // see R7
			pullup_ff <= supervisor_control_one_ff[`CSW_B_PULLUP] ? // see R17
				(~gpio_dir_out & general_pin_output_byte_ff[3:0]) : 4'h0;
			mismatch_ff <= (expected_model_ff != `CSW_OWN_MODEL); // see R1
			save_ff <= (state_ff == CSW_SAVE);
			if (supervisor_control_one_ff[`CSW_B_LAMPOFF]) begin
				lamp_ff <= 1'b0; // see R16
			end else if (state_ff == CSW_RUN) begin
				lamp_ff <= 1'b1;
			end else begin
				// see R9
				lamp_ff <= !flash_ph_ff[0] && (flash_ph_ff[2:1] < cause_ff);
			end
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign dout = dout_ff;
	assign pwm_oe = pwm_oe_ff;
	assign gpio_pullup = pullup_ff;
	assign status_lamp = lamp_ff;
	assign model_mismatch = mismatch_ff;
	assign save_strobe = save_ff;
	assign state = state_ff;

	// ==========================================================
	// Checks
	a_safe_holds: assert property (@(posedge mclk) disable iff (!rstn) // see R10
		state_ff == CSW_SAFE |=> state_ff == CSW_SAFE) else $error("safe state left");
	a_safe_outs_off: assert property (@(posedge mclk) disable iff (!rstn) // see R6
		state_ff != CSW_RUN |=> dout_ff == 8'h00) else $error("outputs on in safe");
	a_pwm_tristate: assert property (@(posedge mclk) disable iff (!rstn) // see R7
		state_ff != CSW_RUN |=> !pwm_oe_ff) else $error("pwm driven in safe");
	a_force_enters: assert property (@(posedge mclk) disable iff (!rstn) // see R11
		state_ff == CSW_RUN && force_safe |=> state_ff != CSW_RUN) else $error("force ignored");
	a_bad_no_kick: assert property (@(posedge mclk) disable iff (!rstn) // see R5
		wd_on && exch_done && !exch_crc_ok && wd_sel == sel_prev_ff && !timeout
		|=> wd_cnt_ff == $past(wd_cnt_ff) + 32'h1) else $error("bad cycle kicked");
	a_off_no_trip: assert property (@(posedge mclk) disable iff (!rstn) // see R20
		!wd_on |=> wd_cnt_ff == 32'h0) else $error("disabled watchdog counting");
	a_lamp_off: assert property (@(posedge mclk) disable iff (!rstn) // see R16
		supervisor_control_one_ff[`CSW_B_LAMPOFF] |=> !lamp_ff) else $error("lamp not off");
	a_save_path: assert property (@(posedge mclk) disable iff (!rstn) // see R8
		state_ff == CSW_RUN && enter_safe && supervisor_control_one_ff[`CSW_B_RETAIN]
		|=> state_ff == CSW_SAVE) else $error("save skipped");
	a_valid_kick: assert property (@(posedge mclk) disable iff (!rstn) // see R19
		valid_cycle |=> wd_cnt_ff == 32'h0) else $error("valid cycle no restart");
	c_wd_trip: cover property (@(posedge mclk) disable iff (!rstn) timeout && state_ff == CSW_RUN);
	c_force: cover property (@(posedge mclk) disable iff (!rstn) force_safe && state_ff == CSW_RUN);
	c_save_done: cover property (@(posedge mclk) disable iff (!rstn)
		state_ff == CSW_SAVE ##1 state_ff == CSW_SAFE);
	c_mirror_read: cover property (@(posedge mclk) disable iff (!rstn)
		rd_en && bk_in_hit && supervisor_control_one_ff[`CSW_B_MIRROR]);
	c_bad_frame: cover property (@(posedge mclk) disable iff (!rstn)
		wd_on && exch_done && !exch_crc_ok);

	// ==========================================================
	// Bus handshake checks
	// One-cycle answer keeps a held request from being taken on two edges in a row
	a_ready_pulse: assert property (@(posedge mclk) disable iff (!rstn)
		pready_ff |=> !pready_ff) else $error("pready held");
	a_err_with_ready: assert property (@(posedge mclk) disable iff (!rstn)
		pslverr_ff |-> pready_ff) else $error("error without ready");
	a_write_lands: assert property (@(posedge mclk) disable iff (!rstn) // see R3
		wr_en && paddr == `CSW_OFF_CTRL0 |=> supervisor_control_zero_ff == {4'h0, $past(pwdata[3:0])})
		else $error("select write lost");

	// Watchdog and state checks
	a_sel_undoc: assert property (@(posedge mclk) disable iff (!rstn) // see R20
		wd_sel > `CSW_SEL_MAX |-> !wd_on) else $error("undocumented select enabled");
	a_timeout_enters: assert property (@(posedge mclk) disable iff (!rstn) // see R4
		state_ff == CSW_RUN && timeout |=> state_ff != CSW_RUN) else $error("timeout ignored");
	a_sel_restart: assert property (@(posedge mclk) disable iff (!rstn) // see R19
		wd_sel != sel_prev_ff |=> wd_cnt_ff == 32'h0) else $error("select change no restart");
	a_state_legal: assert property (@(posedge mclk) disable iff (!rstn) // see R10
		state_ff inside {CSW_RUN, CSW_SAVE, CSW_SAFE}) else $error("illegal state");
	a_cause_force: assert property (@(posedge mclk) disable iff (!rstn) // see R9
		state_ff == CSW_RUN && force_safe && !timeout |=> cause_ff == CSW_CAUSE_FORCE)
		else $error("force cause lost");
	a_save_ends: assert property (@(posedge mclk) disable iff (!rstn) // see R8
		state_ff == CSW_SAVE && save_idx_ff == 7'd63 |=> state_ff == CSW_SAFE)
		else $error("save did not end");
	a_save_strobe: assert property (@(posedge mclk) disable iff (!rstn) // see R8
		state_ff == CSW_SAVE |=> save_ff) else $error("save strobe missing");
	// Mirroring must never disturb the saved copy
	a_saved_frozen: assert property (@(posedge mclk) disable iff (!rstn) // see R13
		state_ff != CSW_SAVE |=> bk_saved_ff[0] == $past(bk_saved_ff[0]))
		else $error("saved backup changed");

	// Output checks
	a_dout_run: assert property (@(posedge mclk) disable iff (!rstn) // see R6
		state_ff == CSW_RUN && !enter_safe |=> dout_ff == $past(dout_req))
		else $error("outputs not passed in run");
	a_pwm_run: assert property (@(posedge mclk) disable iff (!rstn) // see R7
		state_ff == CSW_RUN && !enter_safe |=> pwm_oe_ff) else $error("pwm off in run");
	a_pullup_gate: assert property (@(posedge mclk) disable iff (!rstn) // see R17
		!supervisor_control_one_ff[`CSW_B_PULLUP] |=> pullup_ff == 4'h0) else $error("pullup ungated");
	a_lamp_run: assert property (@(posedge mclk) disable iff (!rstn) // see R16
		state_ff == CSW_RUN && !supervisor_control_one_ff[`CSW_B_LAMPOFF] |=> lamp_ff)
		else $error("lamp dark in run");
	a_flash_dark: assert property (@(posedge mclk) disable iff (!rstn) // see R9
		state_ff != CSW_RUN && flash_ph_ff[0] |=> !lamp_ff) else $error("lamp lit in gap phase");
	a_mismatch_flag: assert property (@(posedge mclk) disable iff (!rstn) // see R1
		expected_model_ff != `CSW_OWN_MODEL |=> mismatch_ff) else $error("model mismatch hidden");
endmodule

// ### common/csw_params.svh
// Register offsets, field positions, reset values and timing counts of the supervision watchdog
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH
`define CSW_OFF_MODEL 12'h000
`define CSW_OFF_XMODE 12'h004
`define CSW_OFF_CTRL0 12'h008
`define CSW_OFF_CTRL1 12'h00C
`define CSW_OFF_STAT 12'h010
`define CSW_OFF_EXCH 12'h014
`define CSW_OFF_GPIO 12'h018
`define CSW_OFF_BKOUT 12'h100
`define CSW_OFF_BKIN 12'h200
`define CSW_RST_CTRL 8'h00
`define CSW_RST_MODEL 8'h00
`define CSW_OWN_MODEL 8'h5A
`define CSW_B_SAFE 0
`define CSW_B_MIRROR 1
`define CSW_B_RETAIN 2
`define CSW_B_LAMPOFF 3
`define CSW_B_PULLUP 4
`define CSW_BASE_MS 16
`define CSW_CLK_MHZ 200
`define CSW_BASE_CYC (`CSW_BASE_MS * `CSW_CLK_MHZ * 1000)
`define CSW_SEL_MAX 4'hA
`define CSW_FLASH_CYC (`CSW_CLK_MHZ * 1000 * 250)
`endif

// ### common/csw_pkg.sv
// Types shared by the supervision watchdog
package csw_pkg;
	typedef enum logic [1:0] {
		CSW_RUN = 2'b00,
		CSW_SAVE = 2'b01,
		CSW_SAFE = 2'b10
	} csw_state_e;
	typedef enum logic [1:0] {
		CSW_CAUSE_NONE = 2'b00,
		CSW_CAUSE_WDOG = 2'b01,
		CSW_CAUSE_FORCE = 2'b10
	} csw_cause_e;
endpackage

// ### verif/csw_host_model.sv
// Host model: issues exchange cycle events with good or broken integrity
`timescale 1ns/10ps
module csw_host_model #(
	parameter int PERIOD = 10
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// Control from the bench
	input wire logic run,
	input wire logic bad,
	// Exchange events
	output logic exch_done,
	output logic exch_crc_ok
);
	int cnt_ff;
	// ==========================================================
	// Frame pacing
	// Integrity flag toggles between frames so a stale level is never trusted
	always_ff @(posedge mclk) begin
		exch_done <= rstn && run && cnt_ff == PERIOD - 1;
		exch_crc_ok <= (rstn && run && cnt_ff == PERIOD - 1) ? !bad : !exch_crc_ok && rstn;
		cnt_ff <= (!rstn || !run || cnt_ff == PERIOD - 1) ? 0 : cnt_ff + 1;
	end
endmodule

// ### verif/controller_supervision_watchdog_tb_top.sv
// Self-checking bench of the supervision watchdog
`timescale 1ns/10ps
module controller_supervision_watchdog_tb_top;
	import csw_pkg::*;
	typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} csw_row_s;
	logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic run = 1'b0, bad = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] dout_req = 8'h5C;
	logic [3:0] gpio_dir_out = 4'h5;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, exch_done, exch_crc_ok, pwm_oe, status_lamp, save_strobe, mm;
	logic [7:0] dout;
	logic [3:0] gpio_pullup;
	csw_state_e state;
	int n_errors = 0, compares = 0, n;
	// Last row hits an unmapped word
	csw_row_s rows[8] = '{'{12'h004, 32'hA5, 32'hA5, 1'b0}, '{12'h008, 32'h0, 32'h0, 1'b0},
		'{12'h00C, 32'h18, 32'h18, 1'b0}, '{12'h018, 32'hF, 32'hF, 1'b0},
		'{12'h100, 32'h3C, 32'h3C, 1'b0}, '{12'h014, 32'h77, 32'h0, 1'b0},
		'{12'h200, 32'h55, 32'h0, 1'b0}, '{12'h020, 32'h1, 32'h0, 1'b1}};

	csw_watchdog #(.BASE_CYC(20), .FLASH_CYC(4)) dut_u (.mclk(mclk), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .exch_done(exch_done), .exch_crc_ok(exch_crc_ok),
		.dout_req(dout_req), .gpio_dir_out(gpio_dir_out), .dout(dout), .pwm_oe(pwm_oe),
		.gpio_pullup(gpio_pullup), .status_lamp(status_lamp), .model_mismatch(mm),
		.save_strobe(save_strobe), .state(state));
	csw_host_model #(.PERIOD(10)) host_u (.mclk(mclk), .rstn(rstn), .run(run), .bad(bad),
		.exch_done(exch_done), .exch_crc_ok(exch_crc_ok));

	initial begin
		forever #2.5 mclk = ~mclk;
	end
	// ==========================================================
	// Helpers
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			n_errors++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	task automatic idle(input int k);
		repeat (k) @(posedge mclk);
	endtask
	task automatic wait_st(input csw_state_e s);
		for (n = 0; n < 300 && state !== s; n++) @(posedge mclk);
		if (state !== s) begin
			n_errors++;
			end_of_test();
		end
	endtask
	task automatic rises(input int k);
		logic p;
		n = 0;
		p = status_lamp;
		repeat (k) begin
			@(posedge mclk);
			if (status_lamp === 1'b1 && p === 1'b0) n++;
			p = status_lamp;
		end
	endtask
	task automatic do_reset;
		rstn <= 1'b0;
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		@(posedge mclk);
		do_reset();
		idle(2);
		chk("lamp", status_lamp, 32'h1);
		chk("pwm_oe", pwm_oe, 32'h1);
		chk("mismatch", mm, 32'h1);
		rdc("ctrl1", 12'h00C, 32'h0);
		rdc("ctrl0", 12'h008, 32'h0);
		rdc("status", 12'h010, 32'h8);
		apb(1'b1, 12'h000, 32'h5A);
		rdc("status", 12'h010, 32'h0);
		chk("match", mm, 32'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			chk("wr_err", er, rows[i].e);
			apb(1'b0, rows[i].a, 32'h0);
			chk("rd_err", er, rows[i].e);
			if (!rows[i].e) chk("rdata", rd, rows[i].r);
		end
		$display("test table done");
		idle(3);
		chk("pullup", gpio_pullup, 32'hA);
		chk("lamp_off", status_lamp, 32'h0);
		chk("dout", dout, 32'h5C);
		apb(1'b1, 12'h00C, 32'h2);
		run <= 1'b1;
		idle(30);
		run <= 1'b0;
		rdc("mirror", 12'h200, 32'h3C);
		apb(1'b1, 12'h00C, 32'h0);
		rdc("saved", 12'h200, 32'h0);
		$display("test mirror done");
		run <= 1'b1;
		apb(1'b1, 12'h008, 32'h1);
		idle(150);
		chk("state", state, CSW_RUN);
		run <= 1'b0;
		apb(1'b1, 12'h008, 32'hB);
		idle(150);
		chk("state", state, CSW_RUN);
		run <= 1'b1;
		bad <= 1'b1;
		apb(1'b1, 12'h008, 32'h3);
		wait_st(CSW_SAFE);
		chk("wd_time", n >= 70 && n <= 90, 32'h1);
		chk("dout_safe", dout, 32'h0);
		chk("pwm_safe", pwm_oe, 32'h0);
		rdc("status", 12'h010, 32'h3);
		rises(80);
		chk("flash", n > 0, 32'h1);
		apb(1'b1, 12'h008, 32'h0); // Watchdog left off while idle
		idle(50);
		chk("latched", state, CSW_SAFE);
		run <= 1'b0;
		bad <= 1'b0;
		$display("test watchdog done");
		do_reset();
		chk("state", state, CSW_RUN);
		apb(1'b1, 12'h100, 32'h3C);
		apb(1'b1, 12'h00C, 32'h5); // Backup on only for this save
		wait_st(CSW_SAVE);
		idle(2);
		chk("saving", save_strobe, 32'h1);
		wait_st(CSW_SAFE);
		chk("save_len", n >= 50 && n <= 70, 32'h1);
		rdc("saved", 12'h200, 32'h3C);
		rdc("status", 12'h010, 32'hD);
		apb(1'b1, 12'h00C, 32'h9);
		rises(80);
		chk("lamp_dis", n, 32'h0);
		$display("test force done");
		end_of_test();
	end
endmodule
